/* inc/timer_ccc_pkg.sv */
// Constants, field layouts and types shared by the capture/compare timer.
`default_nettype none
package timer_ccc_pkg;

  // Register byte offsets.
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CTRL2 = 8'h04;
  localparam logic [7:0] OFF_COUNT = 8'h08;
  localparam logic [7:0] OFF_RELOAD = 8'h0c;
  localparam logic [7:0] OFF_CAPTURE = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;

  // Control register field positions.
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_POL_BIT = 3;
  localparam int CTRL_PRE_LSB = 4;
  localparam int CTRL_OEN_BIT = 7;
  localparam int CTRL2_SEL_LSB = 0;
  localparam int CTRL2_CAUSE_BIT = 7;

  // Reset and restart values, and the word transfer size.
  localparam logic [15:0] COUNT_RESTART = 16'h0001;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [15:0] RELOAD_RST = 16'hffff;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef enum logic [1:0] {
    MODE_GATED = 2'b00,
    MODE_COMPARATOR = 2'b01,
    MODE_CAPTURE = 2'b10
  } timer_mode_t;

  typedef enum logic [1:0] {
    IRQ_BOTH = 2'b00,
    IRQ_CAPTURE_ONLY = 2'b01,
    IRQ_RELOAD_ONLY = 2'b10
  } irq_sel_t;

  typedef enum logic {
    CC_ARMED = 1'b0,
    CC_RUN = 1'b1
  } cc_state_t;

endpackage
`default_nettype wire

/* verilog/edge_sync.sv */
// Two-flop synchroniser with rise and fall pulse detection.
`default_nettype none
module edge_sync (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic async_in,
  output logic level,
  output logic rise,
  output logic fall
);

  logic meta_r;
  logic sync_r;
  logic prev_r;

  // The first flop feeds only the second; edges look at the later stages.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  // One-cycle pulses per transition of the synchronised level.
  assign level = sync_r;
  assign rise = sync_r && !prev_r;
  assign fall = !sync_r && prev_r;

endmodule
`default_nettype wire

/* verilog/tick_divider.sv */
// Power-of-two clock divider giving a one-cycle tick enable.
`default_nettype none
module tick_divider (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic run,
  input wire logic [2:0] prescale,
  output logic tick
);

  logic [6:0] div_r;
  logic [6:0] limit;

  // Divide by 2 to the power of prescale; zero ticks every cycle.
  assign limit = 7'((8'h01 << prescale) - 8'h01);
  assign tick = run && (div_r == limit);

  // The divider restarts whenever the timer is stopped.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      div_r <= 7'h00;
    end else if (!run || tick) begin
      div_r <= 7'h00;
    end else begin
      div_r <= div_r + 7'h01;
    end
  end

endmodule
`default_nettype wire

/* verilog/timer_capture_compare_counter.sv */
// Sixteen-bit comparator counter and capture/compare timer with AHB-Lite registers.
`default_nettype none
module timer_capture_compare_counter
  import timer_ccc_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic cmp_out,
  input wire logic timer_in,
  output logic timer_out,
  output logic timer_out_en,
  output logic timer_irq
);

  // True when the count has reached the reload or compare value.
  function automatic logic at_limit(input logic [15:0] cnt, input logic [15:0] lim);
    at_limit = (cnt == lim);
  endfunction

  logic dp_valid_r;
  logic dp_write_r;
  logic [7:0] dp_addr_r;
  logic rd_wait_r;
  logic [31:0] hrdata_r;
  logic addr_take;
  logic wr_en;
  logic wr_ctrl;
  logic wr_count;
  logic en_r;
  timer_mode_t mode_r;
  logic pol_r;
  logic [2:0] pre_r;
  logic oen_r;
  irq_sel_t sel_r;
  logic cause_r;
  logic [15:0] count_r;
  logic [15:0] reload_r;
  logic [15:0] capture_r;
  logic out_r;
  logic irq_r;
  cc_state_t cc_state_r;
  logic cmp_rise;
  logic cmp_fall;
  logic in_level;
  logic in_rise;
  logic in_fall;
  logic tick;
  logic sel_cmp;
  logic sel_in;
  logic deassert;
  logic in_active;
  logic cap_evt;
  logic gate_evt;
  logic rld_evt;
  logic step;
  logic first_edge;

  // Input synchronisers for the comparator output and the timer input pin.
  // synchronised edge detection.
  edge_sync u_cmp_sync (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .async_in(cmp_out),
    .level(),
    .rise(cmp_rise),
    .fall(cmp_fall)
  );

  edge_sync u_in_sync (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .async_in(timer_in),
    .level(in_level),
    .rise(in_rise),
    .fall(in_fall)
  );

  // Prescaled system-clock tick for capture and gated counting.
  // prescaled clock counting.
  tick_divider u_div (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .run(en_r),
    .prescale(pre_r),
    .tick(tick)
  );

  // Address phase is taken only for whole-word transfers.
  assign addr_take = hsel && hready && htrans[1] && (hsize == HSIZE_WORD);
  assign wr_en = dp_valid_r && dp_write_r;
  assign wr_ctrl = wr_en && (dp_addr_r == OFF_CTRL);
  assign wr_count = wr_en && (dp_addr_r == OFF_COUNT);

  // Bus pipeline: writes finish with no wait, reads add one wait state.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      dp_valid_r <= 1'b0;
      dp_write_r <= 1'b0;
      dp_addr_r <= 8'h00;
      rd_wait_r <= 1'b0;
    end else if (hready) begin
      dp_valid_r <= addr_take;
      dp_write_r <= hwrite;
      dp_addr_r <= haddr[7:0];
      rd_wait_r <= addr_take && !hwrite;
    end else begin
      rd_wait_r <= 1'b0;
    end
  end

  assign hreadyout = !rd_wait_r;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;

  // Read data is registered during the wait state; unmapped words read zero.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      hrdata_r <= 32'h0000_0000;
    end else if (rd_wait_r) begin
      unique case (dp_addr_r)
        OFF_CTRL: hrdata_r <= {24'h000000, oen_r, pre_r, pol_r, mode_r, en_r};
        OFF_CTRL2: hrdata_r <= {24'h000000, cause_r, 5'h00, sel_r};
        OFF_COUNT: hrdata_r <= {16'h0000, count_r};
        OFF_RELOAD: hrdata_r <= {16'h0000, reload_r};
        OFF_CAPTURE: hrdata_r <= {16'h0000, capture_r};
        OFF_STATUS: hrdata_r <= {29'h0000000, cc_state_r, in_level, out_r};
        default: hrdata_r <= 32'h0000_0000;
      endcase
    end
  end

  // Control register fields written by software.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      en_r <= 1'b0;
      mode_r <= MODE_GATED;
      pol_r <= 1'b0;
      pre_r <= 3'h0;
      oen_r <= 1'b0;
    end else if (wr_ctrl) begin
      en_r <= hwdata[CTRL_EN_BIT];
      mode_r <= timer_mode_t'(hwdata[CTRL_MODE_LSB +: 2]);
      pol_r <= hwdata[CTRL_POL_BIT];
      pre_r <= hwdata[CTRL_PRE_LSB +: 3];
      oen_r <= hwdata[CTRL_OEN_BIT];
    end
  end

  // Interrupt source select in the second control register.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sel_r <= IRQ_BOTH;
    end else if (wr_en && (dp_addr_r == OFF_CTRL2)) begin
      sel_r <= irq_sel_t'(hwdata[CTRL2_SEL_LSB +: 2]);
    end
  end

  // Reload or compare value.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      reload_r <= RELOAD_RST;
    end else if (wr_en && (dp_addr_r == OFF_RELOAD)) begin
      reload_r <= hwdata[15:0];
    end
  end

  // Polarity picks edges; gated mode counts while the input is at that level.
  // edge selection.
  assign sel_cmp = pol_r ? cmp_rise : cmp_fall;
  assign sel_in = pol_r ? in_rise : in_fall;
  assign deassert = pol_r ? in_fall : in_rise;
  assign in_active = (in_level == pol_r);
  assign first_edge = en_r && (mode_r == MODE_CAPTURE) && (cc_state_r == CC_ARMED) && sel_in;

  // Event decode for the selected mode; nothing happens while disabled.
  // disabled hold.
  always_comb begin
    cap_evt = 1'b0;
    gate_evt = 1'b0;
    rld_evt = 1'b0;
    step = 1'b0;
    if (en_r) begin
      unique case (mode_r)
        MODE_COMPARATOR: begin
          if (sel_cmp) begin
            rld_evt = at_limit(count_r, reload_r);
            step = !at_limit(count_r, reload_r);
          end
        end
        MODE_CAPTURE: begin
          if (cc_state_r == CC_RUN) begin
            if (sel_in) begin
              cap_evt = 1'b1;
            end else if (tick) begin
              rld_evt = at_limit(count_r, reload_r);
              step = !at_limit(count_r, reload_r);
            end
          end
        end
        MODE_GATED: begin
          if (deassert) begin
            gate_evt = 1'b1;
          end else if (tick && in_active) begin
            rld_evt = at_limit(count_r, reload_r);
            step = !at_limit(count_r, reload_r);
          end
        end
        default: begin
          step = 1'b0;
        end
      endcase
    end
  end

  // Capture start state: armed until the first selected input edge.
  // wait for first edge.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cc_state_r <= CC_ARMED;
    end else if (wr_ctrl) begin
      cc_state_r <= CC_ARMED;
    end else if (first_edge) begin
      cc_state_r <= CC_RUN;
    end
  end

  // Count: software write first, then restart at one, then single steps.
  // counting.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      count_r <= COUNT_RST;
    end else if (wr_count) begin
      count_r <= hwdata[15:0];
    end else if (cap_evt || rld_evt) begin
      count_r <= COUNT_RESTART;
    end else if (step) begin
      count_r <= count_r + 16'h0001;
    end
  end

  // Capture register takes the running count on a capture edge.
  // capture copy.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      capture_r <= COUNT_RST;
    end else if (cap_evt) begin
      capture_r <= count_r;
    end else if (wr_en && (dp_addr_r == OFF_CAPTURE)) begin
      capture_r <= hwdata[15:0];
    end
  end

  // Cause flag: set by a capture, cleared by a capture-mode reload whatever the interrupt select.
  // cause flag.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cause_r <= 1'b0;
    end else if (cap_evt) begin
      cause_r <= 1'b1;
    end else if (rld_evt && (mode_r == MODE_CAPTURE)) begin
      cause_r <= 1'b0;
    end
  end

  // Output takes its starting level at enable and inverts at each reload while the output enable is set.
  // output level.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      out_r <= 1'b0;
    end else if (wr_ctrl && hwdata[CTRL_EN_BIT] && !en_r) begin
      out_r <= hwdata[CTRL_POL_BIT];
    end else if (rld_evt && oen_r) begin
      out_r <= !out_r;
    end
  end

  assign timer_out = out_r;
  assign timer_out_en = oen_r;

  // One-cycle interrupt pulse filtered by the source select.
  // interrupt select.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= ((cap_evt || gate_evt) && (sel_r != IRQ_RELOAD_ONLY)) ||
               (rld_evt && (sel_r != IRQ_CAPTURE_ONLY));
    end
  end

  assign timer_irq = irq_r;

  // Comparator wrap: selected edge at the reload value with no count write.
  sequence s_cc_wrap;
    en_r && (mode_r == MODE_COMPARATOR) && sel_cmp && (count_r == reload_r) && !wr_count;
  endsequence

  // Restart seen one cycle later.
  sequence s_restart;
    count_r == COUNT_RESTART;
  endsequence

  // Capture edge while running.
  sequence s_capture;
    en_r && (mode_r == MODE_CAPTURE) && (cc_state_r == CC_RUN) && sel_in && !wr_count;
  endsequence

  cc_reload_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    s_cc_wrap |=> s_restart and (timer_irq == ($past(sel_r) != IRQ_CAPTURE_ONLY)))
    else $error("comparator reload did not restart and interrupt");

  out_toggle_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    s_cc_wrap ##0 oen_r && !wr_ctrl |=> timer_out != $past(timer_out))
    else $error("timer output did not invert at reload");

  start_level_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    $rose(en_r) |-> timer_out == pol_r)
    else $error("timer output starting level differs from edge choice");

  count_step_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    en_r && (mode_r == MODE_COMPARATOR) && sel_cmp && (count_r != reload_r) && !wr_count
    |=> count_r == $past(count_r) + 16'h0001)
    else $error("comparator count did not step by one");

  armed_hold_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    en_r && (mode_r == MODE_CAPTURE) && (cc_state_r == CC_ARMED) && !wr_count
    |=> $stable(count_r))
    else $error("capture counting began before the first edge");

  capture_copy_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    s_capture |=> (capture_r == $past(count_r)) and s_restart and cause_r)
    else $error("capture did not copy, restart and flag");

  compare_clear_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    rld_evt && (mode_r == MODE_CAPTURE) |=> !cause_r ##1 1'b1)
    else $error("compare interrupt left capture cause set");

  irq_filter_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    s_capture ##0 (sel_r == IRQ_RELOAD_ONLY) |=> !timer_irq)
    else $error("capture interrupt fired under reload-only select");

  idle_hold_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    !en_r && !wr_count && !wr_ctrl |=> $stable(count_r) && !timer_irq && $stable(timer_out))
    else $error("disabled timer changed count, output or interrupt");

endmodule
`default_nettype wire

/* verif/timer_partner.sv */
// Far-side model that drives the comparator output and the timer input pin.
`default_nettype none
module timer_partner (
  input wire logic core_clk,
  output logic cmp_out,
  output logic timer_in
);
  timeunit 1ns;
  timeprecision 1ps;

  // Both lines rest low until a scenario asks for edges.
  initial begin
    cmp_out = 1'b0;
    timer_in = 1'b0;
  end

  // slow toggling
  // The high level holds four clocks and the low level five, so the line never toggles faster than a quarter clock.
  task automatic cmp_pulse(input int n);
    repeat (n) begin
      @(posedge core_clk) cmp_out <= 1'b1;
      repeat (4) @(posedge core_clk);
      cmp_out <= 1'b0;
      repeat (4) @(posedge core_clk);
    end
  endtask

  // input assertion
  // One rising edge, low again after four clocks; gap is the spacing to the next rise.
  task automatic tin_rise(input int gap);
    @(posedge core_clk) timer_in <= 1'b1;
    repeat (4) @(posedge core_clk);
    timer_in <= 1'b0;
    repeat (gap - 5) @(posedge core_clk);
  endtask
endmodule
`default_nettype wire

/* verif/timer_capture_compare_counter_bench.sv */
// Self-checking bench for the capture/compare timer.
`default_nettype none
module timer_capture_compare_counter_bench import timer_ccc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic core_clk, arst_n, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic cmp_out, timer_in, timer_out, timer_out_en, timer_irq;
  int errors = 0;
  int cmp_count = 0;
  int irq_cnt = 0;
  int cyc = 0;
  logic [7:0] rst_off [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h20};
  logic [31:0] rst_val [6] = '{32'h0, 32'h0, 32'h0, 32'hffff, 32'h0, 32'h0};

  // The single slave's ready is the bus ready.
  assign hready = hreadyout;

  timer_capture_compare_counter dut_u (
    .core_clk(core_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cmp_out(cmp_out),
    .timer_in(timer_in), .timer_out(timer_out), .timer_out_en(timer_out_en),
    .timer_irq(timer_irq)
  );

  timer_partner partner_u (.core_clk(core_clk), .cmp_out(cmp_out), .timer_in(timer_in));

  // Clock at 100 MHz.
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Counts interrupt pulses and cuts a hang short.
  always @(posedge core_clk) begin
    if (timer_irq === 1'b1) irq_cnt <= irq_cnt + 1;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      $display("[ERR] %0t timeout", $time);
      stop_test();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask

  // One single word transfer; waits for ready in both phases.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge core_clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    check(x, e);
  endtask

  task automatic pulses(input int n);
    partner_u.cmp_pulse(n);
    repeat (6) @(posedge core_clk);
  endtask

  task automatic reset_test();
    check(timer_out, 32'h0);
    check(timer_out_en, 32'h0);
    check(hresp, 32'h0);
    for (int i = 0; i < 6; i++) rd_chk(rst_off[i], rst_val[i]);
    // A byte-sized write is ignored by the slave.
    hsize <= 3'h0;
    wr(OFF_RELOAD, 32'h1234);
    hsize <= HSIZE_WORD;
    rd_chk(OFF_RELOAD, 32'hffff);
  endtask

  task automatic cmp_test();
    int i0;
    wr(OFF_CTRL, 32'h8a);
    wr(OFF_COUNT, 32'h3);
    wr(OFF_RELOAD, 32'h5);
    wr(OFF_CTRL, 32'h8b);
    @(posedge core_clk);
    check(timer_out, 32'h1);
    check(timer_out_en, 32'h1);
    i0 = irq_cnt;
    pulses(2);
    rd_chk(OFF_COUNT, 32'h5);
    check(irq_cnt - i0, 32'h0);
    pulses(1);
    rd_chk(OFF_COUNT, 32'h1);
    check(irq_cnt - i0, 32'h1);
    check(timer_out, 32'h0);
    pulses(4);
    rd_chk(OFF_COUNT, 32'h5);
    pulses(1);
    check(irq_cnt - i0, 32'h2);
    check(timer_out, 32'h1);
    wr(OFF_CTRL, 32'h8a);
    pulses(2);
    rd_chk(OFF_COUNT, 32'h1);
    check(irq_cnt - i0, 32'h2);
    check(timer_out, 32'h1);
  endtask

  task automatic cap_test(input logic [1:0] sel, input logic [2:0] pre);
    int i0;
    logic [31:0] x;
    logic [31:0] c;
    c = {24'h0, 1'b0, pre, 4'hc};
    wr(OFF_CTRL, c);
    wr(OFF_CTRL2, {30'h0, sel});
    wr(OFF_COUNT, 32'h1);
    wr(OFF_RELOAD, 32'h30);
    wr(OFF_CTRL, c | 32'h1);
    repeat (20) @(posedge core_clk);
    rd_chk(OFF_COUNT, 32'h1);
    rd_chk(OFF_STATUS, 32'h1);
    i0 = irq_cnt;
    partner_u.tin_rise(8 << pre);
    partner_u.tin_rise(8);
    repeat (4) @(posedge core_clk);
    bus(1'b0, OFF_CAPTURE, 32'h0, x);
    check(x >= 7 && x <= 10, 32'h1);
    check(irq_cnt - i0, sel != 2'b10);
    if (sel == 2'b00) begin
      bus(1'b0, OFF_CTRL2, 32'h0, x);
      check(x[7], 32'h1);
    end
    rd_chk(OFF_STATUS, 32'h5);
    i0 = irq_cnt;
    repeat ((48 << pre) + 20) @(posedge core_clk);
    check(irq_cnt - i0, sel != 2'b01);
    if (sel == 2'b00) begin
      bus(1'b0, OFF_CTRL2, 32'h0, x);
      check(x[7], 32'h0);
    end
  endtask

  // Gated mode: counts four ticks while the input is high, interrupts on its fall.
  task automatic gate_test();
    int i0;
    wr(OFF_CTRL, 32'h08);
    wr(OFF_CTRL2, 32'h1);
    wr(OFF_COUNT, 32'h1);
    wr(OFF_RELOAD, 32'h30);
    wr(OFF_CTRL, 32'h09);
    repeat (10) @(posedge core_clk);
    rd_chk(OFF_COUNT, 32'h1);
    i0 = irq_cnt;
    partner_u.tin_rise(20);
    rd_chk(OFF_COUNT, 32'h5);
    check(irq_cnt - i0, 32'h1);
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Reset for two cycles, then run every scenario in turn.
  initial begin
    arst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = HSIZE_WORD;
    hwdata = 32'h0;
    repeat (2) @(posedge core_clk);
    arst_n <= 1'b1;
    reset_test();
    cmp_test();
    cap_test(2'b00, 3'h0);
    cap_test(2'b01, 3'h3);
    cap_test(2'b10, 3'h0);
    gate_test();
    stop_test();
  end
endmodule
`default_nettype wire
